// *** power_seq_pkg.sv ***
// Constants, register map and state type for the dual rail power sequencer
//
// Overview of operation
// [R1] Voltage select pin picks low or high rail_a level
// [R2] Supervisor delays 33 us, running independently
// [R3] Power-up waits until both rails discharged
// [R4] Rail never discharged keeps device powered down
// [R5] Aux flag mirrors aux input against reference
// [R6] Thermal trip sets hot, clears when cool
// [R7] Thermal trip forces both regulator enables off
// [R8] Thermal release restarts power-up from beginning
// [R9] Combined enable is enable AND undervoltage ok; code also ANDs control register sw_enable_r
// [R10] Order select swaps rail order, down reversed
// [R11] Idle with regulators off while disabled
// [R12] Enable rise pulses first ramp reset, starts ramp
// [R13] First rail above threshold starts its delay
// [R14] First delay done restarts and ramps second rail
// [R15] Second rail above threshold starts its delay
// [R16] Second delay done raises rails valid flag
// [R17] Enable fall drops valid, disables first-off rail
// [R18] First-off rail discharged disables other rail
// [R19] Last rail discharged returns to idle
// [R20] Controller stays disabled while valid flag low
// [R21] Discharge switch is inverse of regulator enable
// [R22] Soft-start ramp lasts 260 us
// [R23] Enable fall during power-up starts power-down
// [R24] Asynchronous inputs pass two-stage synchronizer; code registers regulator_a_voltage_select and valid/aux readbacks once
`default_nettype none

package power_seq_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SVS_DELAY_NS   = 33000;
  localparam int RAMP_TIME_NS   = 260000;
  localparam int SVS_DELAY_CYC  = SVS_DELAY_NS / CLK_PERIOD_NS;
  localparam int RAMP_CYC       = RAMP_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 17;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam int          CTRL_SW_EN_BIT  = 0;
  localparam logic        CTRL_SW_EN_RST  = 1'b1;
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_EN_A_BIT     = 4;
  localparam int          ST_EN_B_BIT     = 5;
  localparam int          ST_VALID_BIT    = 6;
  localparam int          ST_THERM_BIT    = 7;
  localparam int          ST_AUX_BIT      = 8;
  localparam int          ST_COMB_EN_BIT  = 9;
  localparam int          ST_ORDER_BIT    = 10;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_UP1_RAMP,
    ST_UP1_DELAY,
    ST_UP2_RAMP,
    ST_UP2_DELAY,
    ST_RUN,
    ST_DOWN1,
    ST_DOWN2
  } seq_state_e;

endpackage

`default_nettype wire

// *** power_seq.sv ***
// Dual rail power sequencer with AHB-Lite status and control registers
`timescale 1ns/10ps
`default_nettype none

module power_seq
  import power_seq_pkg::*;
#(
  parameter int SVS_DELAY_CYCLES = SVS_DELAY_CYC,
  parameter int RAMP_CYCLES      = RAMP_CYC
)
(
  input  wire logic        clock,                 // System clock, 250 MHz
  input  wire logic        reset_n,               // Async reset, active low
  // AHB-Lite slave
  input  wire logic        hsel,                  // Slave select
  input  wire logic [31:0] haddr,                 // Byte address
  input  wire logic [1:0]  htrans,                // Transfer type
  input  wire logic        hwrite,                // Write when high
  input  wire logic [2:0]  hsize,                 // Transfer size
  input  wire logic [31:0] hwdata,                // Write data
  input  wire logic        hready,                // Bus ready in
  output logic      [31:0] hrdata,                // Read data
  output logic             hreadyout,             // Slave ready
  output logic             hresp,                 // Always OKAY
  // Pins and comparators
  input  wire logic        ext_enable,            // External enable pin
  input  wire logic        input_undervoltage_lock_ok,               // Undervoltage lock ok
  input  wire logic        temp_above_upper,      // Junction above trip point
  input  wire logic        temp_above_lower,      // Junction above release point
  input  wire logic        order_select,          // Rail order select
  input  wire logic        regulator_a_voltage_select,   // Regulator_a level select
  input  wire logic        rail_a_supervisor,     // Rail_a above supervisor level
  input  wire logic        rail_b_supervisor,     // Rail_b above supervisor level
  input  wire logic        rail_a_off_threshold,  // Rail_a below discharge level
  input  wire logic        rail_b_off_threshold,  // Rail_b below discharge level
  input  wire logic        aux_monitor_input,     // Aux input above reference
  input  wire logic        rails_valid_in,        // Valid pin level read back
  input  wire logic        aux_flag_in,           // Aux pin level read back
  output logic             regulator_a_enable,    // Regulator_a on
  output logic             regulator_b_enable,    // Regulator_b on
  output logic             rail_a_discharge,      // Rail_a pull-down on
  output logic             rail_b_discharge,      // Rail_b pull-down on
  output logic             ramp_node_first,       // Ramp restart pulse, first rail
  output logic             ramp_node_second,      // Ramp restart pulse, second rail
  output logic             ramp_a_active,         // Rail_a soft-start running
  output logic             ramp_b_active,         // Rail_b soft-start running
  output logic             delay_node_first,      // First rail delay running
  output logic             delay_node_second,     // Second rail delay running
  output logic             regulator_a_level_high,// Regulator_a high output level
  output logic             thermal_trip,          // Thermal shutdown active
  output logic             rails_valid_out,       // Open-drain data, always low
  output logic             rails_valid_oe,        // Pulls valid pin low
  output logic             aux_flag_out,          // Open-drain data, always low
  output logic             aux_flag_oe            // Pulls aux flag pin low
);

  // ---------------------------------------------------------------
  // Input synchronizers
  // ---------------------------------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic             en_s;
  logic             input_undervoltage_lock_s;
  logic             hot_up_s;
  logic             hot_lo_s;
  logic             order_s;
  logic             sup_a_s;
  logic             sup_b_s;
  logic             off_a_s;
  logic             off_b_s;
  logic             aux_s;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {aux_monitor_input, rail_b_off_threshold, rail_a_off_threshold,
                 rail_b_supervisor, rail_a_supervisor, order_select,
                 temp_above_lower, temp_above_upper, input_undervoltage_lock_ok, ext_enable}; // [R24]
      sync_r <= meta_r;                                                    // [R24]
    end
  end

  assign {aux_s, off_b_s, off_a_s, sup_b_s, sup_a_s, order_s,
          hot_lo_s, hot_up_s, input_undervoltage_lock_s, en_s} = sync_r;

  // ---------------------------------------------------------------
  // Control register and combined enable
  // ---------------------------------------------------------------
  logic sw_enable_r;
  logic comb_en;
  logic order_r;

  assign comb_en = en_s & input_undervoltage_lock_s & sw_enable_r; // [R9]

  // ---------------------------------------------------------------
  // Thermal trip with hysteresis
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      thermal_trip <= 1'b0;
    else if (hot_up_s)
      thermal_trip <= 1'b1;   // [R6]
    else if (!hot_lo_s)
      thermal_trip <= 1'b0;   // [R6]
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  seq_state_e      state_r;
  seq_state_e      state_nxt;
  logic [CNT_W-1:0] dly_a_r;
  logic [CNT_W-1:0] dly_b_r;
  logic [CNT_W-1:0] ramp_a_r;
  logic [CNT_W-1:0] ramp_b_r;
  logic             sup_first;
  logic             sup_second;
  logic             off_first;
  logic             off_second;
  logic             dly_first_done;
  logic             dly_second_done;

  function automatic logic pick(input logic sel, input logic a, input logic b);
    pick = sel ? b : a;
  endfunction

  // Core (rail_a) leads when order is low
  assign sup_first       = pick(order_r, sup_a_s, sup_b_s);                  // [R10]
  assign sup_second      = pick(order_r, sup_b_s, sup_a_s);                  // [R10]
  assign off_first       = pick(order_r, off_a_s, off_b_s);
  assign off_second      = pick(order_r, off_b_s, off_a_s);
  assign dly_first_done  = pick(order_r, dly_a_r == CNT_W'(SVS_DELAY_CYCLES),
                                dly_b_r == CNT_W'(SVS_DELAY_CYCLES));
  assign dly_second_done = pick(order_r, dly_b_r == CNT_W'(SVS_DELAY_CYCLES),
                                dly_a_r == CNT_W'(SVS_DELAY_CYCLES));

  always_comb
  begin
    state_nxt = state_r;
    if (thermal_trip)
      state_nxt = ST_DOWN2;                                  // [R7] [R8]
    else
    begin
      unique case (state_r)
        ST_IDLE:      if (comb_en) state_nxt = ST_UP1_RAMP;  // [R11] [R12]
        ST_UP1_RAMP:  if (!comb_en) state_nxt = ST_DOWN1;    // [R23]
                      else if (sup_first) state_nxt = ST_UP1_DELAY; // [R13]
        ST_UP1_DELAY: if (!comb_en) state_nxt = ST_DOWN1;    // [R23]
                      else if (dly_first_done) state_nxt = ST_UP2_RAMP; // [R14]
        ST_UP2_RAMP:  if (!comb_en) state_nxt = ST_DOWN1;    // [R23]
                      else if (sup_second) state_nxt = ST_UP2_DELAY; // [R15]
        ST_UP2_DELAY: if (!comb_en) state_nxt = ST_DOWN1;    // [R23]
                      else if (dly_second_done) state_nxt = ST_RUN; // [R16]
        ST_RUN:       if (!comb_en) state_nxt = ST_DOWN1;    // [R17]
        ST_DOWN1:     if (off_second) state_nxt = ST_DOWN2;  // [R18]
        ST_DOWN2:     if (off_first && off_second)
                        state_nxt = ST_IDLE;                 // [R3] [R4] [R19]
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Order latched only at idle so a pin change cannot split a sequence
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      order_r <= 1'b0;
    else if (state_r == ST_IDLE)
      order_r <= order_s;  // [R10]
  end

  // ---------------------------------------------------------------
  // Enables, discharge switches and valid flag
  // ---------------------------------------------------------------
  logic first_on_nxt;
  logic second_on_nxt;
  logic en_a_nxt;
  logic en_b_nxt;
  logic valid_nxt;

  assign first_on_nxt  = !thermal_trip && state_nxt inside {ST_UP1_RAMP, ST_UP1_DELAY,
                         ST_UP2_RAMP, ST_UP2_DELAY, ST_RUN, ST_DOWN1};
  assign second_on_nxt = !thermal_trip && state_nxt inside {ST_UP2_RAMP, ST_UP2_DELAY,
                         ST_RUN};
  assign en_a_nxt      = pick(order_r, first_on_nxt, second_on_nxt);
  assign en_b_nxt      = pick(order_r, second_on_nxt, first_on_nxt);
  assign valid_nxt     = (state_nxt == ST_RUN);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regulator_a_enable <= 1'b0;
      regulator_b_enable <= 1'b0;
      rail_a_discharge   <= 1'b1;
      rail_b_discharge   <= 1'b1;
    end
    else
    begin
      regulator_a_enable <= en_a_nxt;   // [R7] [R10] [R17] [R18]
      regulator_b_enable <= en_b_nxt;   // [R7] [R10] [R17] [R18]
      rail_a_discharge   <= !en_a_nxt;  // [R21]
      rail_b_discharge   <= !en_b_nxt;  // [R21]
    end
  end

  // Pin pulled low holds the controller in reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rails_valid_oe <= 1'b1;
    else
      rails_valid_oe <= !valid_nxt;  // [R16] [R17] [R20]
  end

  assign rails_valid_out = 1'b0;

  // ---------------------------------------------------------------
  // Ramp restart pulses and soft-start timers
  // ---------------------------------------------------------------
  logic start_first;
  logic start_second;
  logic start_a;
  logic start_b;

  assign start_first  = (state_r == ST_IDLE) && (state_nxt == ST_UP1_RAMP);
  assign start_second = (state_r == ST_UP1_DELAY) && (state_nxt == ST_UP2_RAMP);
  assign start_a      = pick(order_r, start_first, start_second);
  assign start_b      = pick(order_r, start_second, start_first);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ramp_node_first  <= 1'b0;
      ramp_node_second <= 1'b0;
    end
    else
    begin
      ramp_node_first  <= start_first;   // [R12]
      ramp_node_second <= start_second;  // [R14]
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ramp_a_r      <= '0;
      ramp_b_r      <= '0;
      ramp_a_active <= 1'b0;
      ramp_b_active <= 1'b0;
    end
    else
    begin
      if (start_a || !en_a_nxt)
        ramp_a_r <= '0;
      else if (ramp_a_r != CNT_W'(RAMP_CYCLES))
        ramp_a_r <= ramp_a_r + 1'b1;                                   // [R22]
      if (start_b || !en_b_nxt)
        ramp_b_r <= '0;
      else if (ramp_b_r != CNT_W'(RAMP_CYCLES))
        ramp_b_r <= ramp_b_r + 1'b1;                                   // [R22]
      ramp_a_active <= en_a_nxt && (ramp_a_r < CNT_W'(RAMP_CYCLES - 1)); // [R22]
      ramp_b_active <= en_b_nxt && (ramp_b_r < CNT_W'(RAMP_CYCLES - 1)); // [R22]
    end
  end

  // ---------------------------------------------------------------
  // Supervisor delay timers, one per rail
  // ---------------------------------------------------------------
  logic dly_first_run;
  logic dly_second_run;
  logic dly_a_run;
  logic dly_b_run;

  assign dly_first_run  = (state_r == ST_UP1_DELAY);
  assign dly_second_run = (state_r == ST_UP2_DELAY);
  assign dly_a_run      = pick(order_r, dly_first_run, dly_second_run);
  assign dly_b_run      = pick(order_r, dly_second_run, dly_first_run);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dly_a_r <= '0;
      dly_b_r <= '0;
    end
    else
    begin
      dly_a_r <= dly_a_run ? dly_a_r + 1'b1 : '0;  // [R2]
      dly_b_r <= dly_b_run ? dly_b_r + 1'b1 : '0;  // [R2]
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      delay_node_first  <= 1'b0;
      delay_node_second <= 1'b0;
    end
    else
    begin
      delay_node_first  <= (state_nxt == ST_UP1_DELAY);  // [R13]
      delay_node_second <= (state_nxt == ST_UP2_DELAY);  // [R15]
    end
  end

  // ---------------------------------------------------------------
  // Aux monitor and voltage select, independent of the sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_flag_oe            <= 1'b1;
      regulator_a_level_high <= 1'b0;
    end
    else
    begin
      aux_flag_oe            <= !aux_s;               // [R5]
      regulator_a_level_high <= regulator_a_voltage_select;  // [R1]
    end
  end

  assign aux_flag_out = 1'b0;

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  logic        acc_valid;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] status_word;

  assign acc_valid = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb
  begin
    status_word                 = '0;
    status_word[ST_STATE_LSB+:4] = state_r;
    status_word[ST_EN_A_BIT]    = regulator_a_enable;
    status_word[ST_EN_B_BIT]    = regulator_b_enable;
    status_word[ST_VALID_BIT]   = rails_valid_in;
    status_word[ST_THERM_BIT]   = thermal_trip;
    status_word[ST_AUX_BIT]     = aux_flag_in;
    status_word[ST_COMB_EN_BIT] = comb_en;
    status_word[ST_ORDER_BIT]   = order_r;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_r <= acc_valid && hwrite;
      wr_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc_valid && !hwrite)
      begin
        if (haddr[7:0] == CTRL_OFS)
          hrdata <= {31'h0, sw_enable_r};
        else if (haddr[7:0] == STATUS_OFS)
          hrdata <= status_word;
        else
          hrdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      sw_enable_r <= CTRL_SW_EN_RST;
    else if (wr_pend_r && wr_addr_r == CTRL_OFS)
      sw_enable_r <= hwdata[CTRL_SW_EN_BIT];
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_discharge_inverse;
    @(posedge clock) disable iff (!reset_n)
      (rail_a_discharge == !regulator_a_enable) && (rail_b_discharge == !regulator_b_enable);
  endproperty
  a_discharge_inverse: assert property (p_discharge_inverse) // [R21]
    else $error("discharge switch not inverse of enable");

  property p_thermal_off;
    @(posedge clock) disable iff (!reset_n)
      thermal_trip |=> !regulator_a_enable && !regulator_b_enable;
  endproperty
  a_thermal_off: assert property (p_thermal_off) // [R7]
    else $error("regulator enabled during thermal trip");

  property p_thermal_hold;
    @(posedge clock) disable iff (!reset_n)
      thermal_trip && hot_lo_s |=> thermal_trip;
  endproperty
  a_thermal_hold: assert property (p_thermal_hold) // [R6]
    else $error("thermal trip released above lower point");

  property p_valid_drop;
    @(posedge clock) disable iff (!reset_n)
      (state_r == ST_RUN) && !comb_en && !thermal_trip |=> rails_valid_oe && (state_r == ST_DOWN1);
  endproperty
  a_valid_drop: assert property (p_valid_drop) // [R17]
    else $error("valid flag not dropped on disable");

  property p_first_pulse;
    @(posedge clock) disable iff (!reset_n)
      (state_r == ST_IDLE) && comb_en && !thermal_trip |=> ramp_node_first ##1 !ramp_node_first;
  endproperty
  a_first_pulse: assert property (p_first_pulse) // [R12]
    else $error("first ramp restart pulse missing");

  property p_valid_rise;
    @(posedge clock) disable iff (!reset_n)
      $fell(rails_valid_oe) |-> $past(state_r) == ST_UP2_DELAY;
  endproperty
  a_valid_rise: assert property (p_valid_rise) // [R16]
    else $error("valid flag raised outside second delay end");

  property p_wait_discharge;
    @(posedge clock) disable iff (!reset_n)
      (state_r == ST_DOWN2) && !(off_a_s && off_b_s) |=> state_r != ST_IDLE;
  endproperty
  a_wait_discharge: assert property (p_wait_discharge) // [R3]
    else $error("idle reached before both rails discharged");

  property p_order;
    @(posedge clock) disable iff (!reset_n)
      $rose(regulator_b_enable) && !order_r |-> regulator_a_enable;
  endproperty
  a_order: assert property (p_order) // [R10]
    else $error("rail_b enabled before rail_a");

  property p_aux;
    @(posedge clock) disable iff (!reset_n)
      aux_s |=> !aux_flag_oe;
  endproperty
  a_aux: assert property (p_aux) // [R5]
    else $error("aux flag not released");

endmodule

`default_nettype wire

// *** rail_load.sv ***
// Behavioural rails and controller powered by the sequencer
`timescale 1ns/10ps
`default_nettype none

module rail_load
#(
  parameter int RISE = 12
)
(
  input  wire logic clock,                // System clock
  input  wire logic reset_n,              // Async reset, active low
  input  wire logic regulator_a_enable,   // Rail_a regulator on
  input  wire logic regulator_b_enable,   // Rail_b regulator on
  input  wire logic rails_valid_pin,      // Pulled-up valid pin level
  input  wire logic stick_b,              // Fault: rail_b never discharges
  output logic      rail_a_supervisor,    // Rail_a above supervisor level
  output logic      rail_b_supervisor,    // Rail_b above supervisor level
  output logic      rail_a_off_threshold, // Rail_a below discharge level
  output logic      rail_b_off_threshold, // Rail_b below discharge level
  output logic      mcu_running           // Controller out of its own reset
);
  int lvl_a;
  int lvl_b;

  // Slow ramps so the sequencer really waits on the comparators
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lvl_a <= 0;
      lvl_b <= 0;
    end
    else
    begin
      lvl_a <= regulator_a_enable ? ((lvl_a < RISE) ? lvl_a + 1 : RISE)
                                  : ((lvl_a > 0) ? lvl_a - 1 : 0);
      if (!stick_b)
        lvl_b <= regulator_b_enable ? ((lvl_b < RISE) ? lvl_b + 1 : RISE)
                                    : ((lvl_b > 0) ? lvl_b - 1 : 0);
    end
  end

  assign rail_a_supervisor    = (lvl_a == RISE);
  assign rail_b_supervisor    = (lvl_b == RISE);
  assign rail_a_off_threshold = (lvl_a == 0);
  assign rail_b_off_threshold = (lvl_b == 0);
  assign mcu_running          = rails_valid_pin;
endmodule

`default_nettype wire

// *** dual_rail_power_sequencer_tb.sv ***
// Self-checking testbench for the dual rail power sequencer
`timescale 1ns/10ps
`default_nettype none

module dual_rail_power_sequencer_tb;
  import power_seq_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic ext_enable = 1'b0, input_undervoltage_lock_ok = 1'b1, t_hi = 1'b0, t_lo = 1'b0, order_select = 1'b0;
  logic vsel = 1'b0, aux_in = 1'b1, stick_b = 1'b0, sup_a, sup_b, off_a, off_b;
  logic en_a, en_b, dis_a, dis_b, rn1, rn2, lvl_hi, thermal_trip, v_oe, a_oe;
  logic ra, rb, d1, d2;
  logic [1:0] first_on;
  int err_total = 0, comparisons = 0, p1, p2, na, nd;

  initial forever #2 clock = ~clock;

  power_seq #(.SVS_DELAY_CYCLES(8), .RAMP_CYCLES(20)) i_dut (.clock(clock), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ext_enable(ext_enable),
    .input_undervoltage_lock_ok(input_undervoltage_lock_ok), .temp_above_upper(t_hi), .temp_above_lower(t_lo),
    .order_select(order_select), .regulator_a_voltage_select(vsel), .rail_a_supervisor(sup_a),
    .rail_b_supervisor(sup_b), .rail_a_off_threshold(off_a), .rail_b_off_threshold(off_b),
    .aux_monitor_input(aux_in), .rails_valid_in(!v_oe), .aux_flag_in(!a_oe),
    .regulator_a_enable(en_a), .regulator_b_enable(en_b), .rail_a_discharge(dis_a),
    .rail_b_discharge(dis_b), .ramp_node_first(rn1), .ramp_node_second(rn2), .ramp_a_active(ra),
    .ramp_b_active(rb), .delay_node_first(d1), .delay_node_second(d2),
    .regulator_a_level_high(lvl_hi), .thermal_trip(thermal_trip), .rails_valid_out(),
    .rails_valid_oe(v_oe), .aux_flag_out(), .aux_flag_oe(a_oe));

  rail_load #(.RISE(12)) i_load (.clock(clock), .reset_n(reset_n), .regulator_a_enable(en_a),
    .regulator_b_enable(en_b), .rails_valid_pin(!v_oe), .stick_b(stick_b),
    .rail_a_supervisor(sup_a), .rail_b_supervisor(sup_b), .rail_a_off_threshold(off_a),
    .rail_b_off_threshold(off_b), .mcu_running());

  // Restart pulses and the first rail to turn on, counted from the outside
  always @(posedge clock)
  begin
    p1 <= p1 + int'(rn1 === 1'b1);
    p2 <= p2 + int'(rn2 === 1'b1);
    na <= na + int'(ra === 1'b1) + int'(rb === 1'b1);
    nd <= nd + int'(d1 === 1'b1) + int'(d2 === 1'b1);
    if (first_on == 2'b00)
      first_on <= {en_b, en_a};
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, a, w};
    do @(posedge clock); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask

  task automatic settle(input logic v);
    for (int i = 0; i < 3000 && v_oe !== v; i++) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask

  task automatic arm(input logic ord);
    @(posedge clock) order_select <= ord;
    @(negedge clock);
    {p1, p2, first_on, na, nd} = '0;
  endtask

  // Full power-up then power-down in the chosen rail order
  task automatic cycle(input logic ord);
    arm(ord);
    @(posedge clock) ext_enable <= 1'b1;
    settle(1'b0);
    chk(first_on, ord ? 2'b10 : 2'b01);
    chk({p1[15:0], p2[15:0]}, {16'd1, 16'd1});
    chk({na[15:0], nd[15:0]}, {16'd40, 16'd18});
    ahb(1'b0, 32'h4, 32'h0);
    chk({q[ST_VALID_BIT], q[3:0]}, {1'b1, 4'(ST_RUN)});
    @(posedge clock) ext_enable <= 1'b0;
    repeat (4) @(posedge clock);
    chk({v_oe, en_a, en_b, dis_a, dis_b}, ord ? 5'b10110 : 5'b11001);
    settle(1'b1);
    repeat (60) @(posedge clock);
    chk({en_a, en_b, dis_a, dis_b}, 4'b0011);
    ahb(1'b0, 32'h4, 32'h0);
    chk(q[3:0], 4'(ST_IDLE));
  endtask

  task automatic conclude();
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(4 * 60000);
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    chk({en_a, en_b, dis_a, dis_b, v_oe, lvl_hi}, 6'b001110);
    // Aux flag needs the synchronizer delay before it reads released
    repeat (4) @(posedge clock);
    ahb(1'b0, 32'h4, 32'h0);
    chk(q, 32'h00000100);
    ahb(1'b0, 32'h10, 32'h0);
    chk(q, 32'h0);
    cycle(1'b0);
    cycle(1'b1);
    @(posedge clock) {aux_in, vsel} <= 2'b01;
    repeat (5) @(posedge clock);
    chk({a_oe, lvl_hi}, 2'b11);
    // Dropping undervoltage lock ok disables the sequence
    @(posedge clock) ext_enable <= 1'b1;
    settle(1'b0);
    @(posedge clock) input_undervoltage_lock_ok <= 1'b0;
    repeat (4) @(posedge clock);
    chk(v_oe, 1'b1);
    settle(1'b1);
    repeat (60) @(posedge clock);
    arm(1'b0);
    @(posedge clock) input_undervoltage_lock_ok <= 1'b1;
    settle(1'b0);
    // Trip with hysteresis, then a full restart
    @(posedge clock) {t_hi, t_lo} <= 2'b11;
    repeat (5) @(posedge clock);
    chk({thermal_trip, en_a, en_b}, 3'b100);
    @(posedge clock) t_hi <= 1'b0;
    repeat (100) @(posedge clock);
    chk({thermal_trip, en_a, en_b, v_oe}, 4'b1001);
    arm(1'b0);
    @(posedge clock) t_lo <= 1'b0;
    settle(1'b0);
    chk({thermal_trip, p1[14:0], p2[15:0]}, {1'b0, 15'd1, 16'd1});
    // Rail_b held up: power-down must never finish
    @(posedge clock) {stick_b, ext_enable} <= 2'b10;
    repeat (200) @(posedge clock);
    @(posedge clock) ext_enable <= 1'b1;
    repeat (100) @(posedge clock);
    ahb(1'b0, 32'h4, 32'h0);
    chk({q[3:0], en_b, v_oe}, {4'(ST_DOWN1), 1'b0, 1'b1});
    @(posedge clock) {stick_b, ext_enable} <= 2'b00;
    repeat (100) @(posedge clock);
    // Enable lost in mid power-up: back down, second rail never started
    arm(1'b0);
    @(posedge clock) ext_enable <= 1'b1;
    repeat (8) @(posedge clock);
    ext_enable <= 1'b0;
    repeat (60) @(posedge clock);
    chk({p1[15:0], p2[15:0]}, {16'd1, 16'd0});
    chk({v_oe, en_a, en_b}, 3'b100);
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b0, 32'h0, 32'h0);
    chk(q[CTRL_SW_EN_BIT], 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
